// [emsi_pkg.sv]
package emsi_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [5:0] ADDR_INT_ENABLE = 6'h03;
  localparam logic [5:0] ADDR_EVENT_STATUS = 6'h17;
  localparam logic [5:0] ADDR_CHIP_COND = 6'h18;
  localparam logic [5:0] ADDR_SIGN_FLAGS = 6'h19;
  localparam logic [5:0] ADDR_LOCK = 6'h22;
  localparam logic [5:0] ADDR_RATIO = 6'h31;

  localparam logic [23:0] RST_INT_ENABLE = 24'h000000;
  localparam logic [23:0] RST_EVENT_STATUS = 24'h800000;
  localparam logic [23:0] RST_CHIP_COND = 24'h801800;
  localparam logic [23:0] RST_SIGN_FLAGS = 24'h000000;
  localparam logic [23:0] RST_RATIO = 24'h01999A;

  // Lock codes
  localparam logic [4:0] LOCK_CODE_SET = 5'h16;
  localparam logic [4:0] LOCK_CODE_CLR = 5'h09;

  // Event status fields
  localparam int EV_LOW_RATE_READY = 23;
  localparam int EV_SAMPLE_READY = 22;
  localparam int EV_WATCHDOG = 21;
  localparam int EV_CALC_OVERRUN = 18;
  localparam int EV_VOLT2_SWELL = 17;
  localparam int EV_VOLT1_SWELL = 16;
  localparam int EV_POWER2_RANGE = 15;
  localparam int EV_POWER1_RANGE = 14;
  localparam int EV_CURRENT2_RANGE = 13;
  localparam int EV_CURRENT1_RANGE = 12;
  localparam int EV_VOLT2_RANGE = 11;
  localparam int EV_VOLT1_RANGE = 10;
  localparam int EV_CURRENT2_OVER = 9;
  localparam int EV_CURRENT1_OVER = 8;
  localparam int EV_VOLT2_DIP = 7;
  localparam int EV_VOLT1_DIP = 6;
  localparam int EV_TEMP_UPDATED = 5;
  localparam int EV_FREQ_UPDATED = 4;
  localparam int EV_BAD_COMMAND = 3;
  localparam int EV_RX_CHECKSUM = 2;
  localparam int EV_ROM_CRC = 1;
  localparam int EV_RX_TIMEOUT = 0;
  // Bits 20 and 19 reserved
  localparam logic [23:0] EV_IMPL_MASK = 24'hE7FFFF;

  // Chip condition fields
  localparam int CC_CMD_LSB = 8;
  localparam int CC_OSC_LSB = 0;
  localparam logic [23:0] CC_IMPL_MASK = 24'h00FF0F;
  localparam logic [23:0] SIGN_IMPL_MASK = 24'h00003F;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [23:0] wdata;
  } emsi_req_s;

  // Status inputs from the measurement core
  typedef struct packed {
    logic [7:0] last_command_code;
    logic temp_modulator_osc;
    logic volt_modulator_osc;
    logic current2_modulator_osc;
    logic current1_modulator_osc;
    logic reactive_total_negative;
    logic reactive2_negative;
    logic reactive1_negative;
    logic active_total_negative;
    logic active2_negative;
    logic active1_negative;
  } emsi_core_s;

endpackage

// [emsi_event_bit.sv]
`timescale 1ns/1ps
// ****************************************
// One sticky write-one-to-clear flag
// ****************************************
module emsi_event_bit #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic set_in,
  input wire logic clr_in,
  output logic flag_out
);

  logic flag_r;
  logic flag_nxt;

  // Set beats clear so an event in the clearing cycle survives
  assign flag_nxt = set_in | (flag_r & ~clr_in);
  assign flag_out = flag_r;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      flag_r <= RST_VAL;
    end else begin
      flag_r <= flag_nxt;
    end
  end

endmodule

// [emsi_status_irq.sv]
`timescale 1ns/1ps
// ****************************************
// Event status, interrupt enable, chip condition, sign flags, ratio
// ****************************************
module emsi_status_irq (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // Serial register port (from serial engine, same clock)
  input emsi_pkg::emsi_req_s req_in,
  output logic [23:0] rdata_out,
  output logic rvalid_out,
  output logic wr_blocked_out,
  // Event pulses from the core
  input wire logic low_rate_results_ready_in,
  input wire logic instruction_done_in,
  input wire logic reset_seq_done_in,
  input wire logic sample_results_ready_in,
  input wire logic watchdog_overflow_flag_in,
  input wire logic calc_overrun_flag_in,
  input wire logic volt2_swell_flag_in,
  input wire logic volt1_swell_flag_in,
  input wire logic power2_range_flag_in,
  input wire logic power1_range_flag_in,
  input wire logic current2_range_flag_in,
  input wire logic current1_range_flag_in,
  input wire logic volt2_range_flag_in,
  input wire logic volt1_range_flag_in,
  input wire logic current2_over_flag_in,
  input wire logic current1_over_flag_in,
  input wire logic volt2_dip_flag_in,
  input wire logic volt1_dip_flag_in,
  input wire logic temperature_updated_flag_in,
  input wire logic bad_command_flag_in,
  input wire logic receive_checksum_fault_in,
  input wire logic rom_crc_fault_in,
  input wire logic receive_timeout_flag_in,
  // Levels from the core
  input emsi_pkg::emsi_core_s core_in,
  // Automatic frequency calculation
  input wire logic auto_frequency_enable_in,
  input wire logic ratio_calc_valid_in,
  input wire logic [23:0] ratio_calc_in,
  // Results
  output logic [23:0] line_to_sample_ratio_out,
  output logic host_write_lock_out,
  output logic irq_n_out
);

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic hit(input logic [5:0] a, input logic [5:0] ref_a);
    hit = (a == ref_a);
  endfunction

  logic lock_r;
  logic [4:0] lock_code_r;
  logic wr_any;
  logic wr_exempt;
  logic wr_ok;
  logic wr_enable;
  logic wr_status;
  logic wr_lock;
  logic wr_ratio;

  // Lock leaves the lock word and the three status words writable
  assign wr_any = req_in.wr;
  assign wr_exempt = hit(req_in.addr, emsi_pkg::ADDR_LOCK) | hit(req_in.addr, emsi_pkg::ADDR_EVENT_STATUS)
    | hit(req_in.addr, emsi_pkg::ADDR_CHIP_COND) | hit(req_in.addr, emsi_pkg::ADDR_SIGN_FLAGS);
  assign wr_ok = wr_any & (wr_exempt | ~lock_r);
  assign wr_blocked_out = wr_any & ~wr_ok;
  assign wr_enable = wr_ok & hit(req_in.addr, emsi_pkg::ADDR_INT_ENABLE);
  assign wr_status = wr_ok & hit(req_in.addr, emsi_pkg::ADDR_EVENT_STATUS);
  assign wr_lock = wr_ok & hit(req_in.addr, emsi_pkg::ADDR_LOCK);
  // Host writes the ratio only while the auto calculation is off
  assign wr_ratio = wr_ok & hit(req_in.addr, emsi_pkg::ADDR_RATIO) & ~auto_frequency_enable_in;

  // ****************************************
  // Event status
  // ****************************************
  logic [23:0] ev_set;
  logic [23:0] ev_clr;
  logic [23:0] event_status;
  logic ratio_update;

  assign ratio_update = auto_frequency_enable_in & ratio_calc_valid_in;

  // Set sources per bit
  always_comb begin
    ev_set = '0;
    ev_set[emsi_pkg::EV_LOW_RATE_READY] = low_rate_results_ready_in | instruction_done_in
      | reset_seq_done_in;
    ev_set[emsi_pkg::EV_SAMPLE_READY] = sample_results_ready_in;
    ev_set[emsi_pkg::EV_WATCHDOG] = watchdog_overflow_flag_in;
    ev_set[emsi_pkg::EV_CALC_OVERRUN] = calc_overrun_flag_in;
    ev_set[emsi_pkg::EV_VOLT2_SWELL] = volt2_swell_flag_in;
    ev_set[emsi_pkg::EV_VOLT1_SWELL] = volt1_swell_flag_in;
    ev_set[emsi_pkg::EV_POWER2_RANGE] = power2_range_flag_in;
    ev_set[emsi_pkg::EV_POWER1_RANGE] = power1_range_flag_in;
    ev_set[emsi_pkg::EV_CURRENT2_RANGE] = current2_range_flag_in;
    ev_set[emsi_pkg::EV_CURRENT1_RANGE] = current1_range_flag_in;
    ev_set[emsi_pkg::EV_VOLT2_RANGE] = volt2_range_flag_in;
    ev_set[emsi_pkg::EV_VOLT1_RANGE] = volt1_range_flag_in;
    ev_set[emsi_pkg::EV_CURRENT2_OVER] = current2_over_flag_in;
    ev_set[emsi_pkg::EV_CURRENT1_OVER] = current1_over_flag_in;
    ev_set[emsi_pkg::EV_VOLT2_DIP] = volt2_dip_flag_in;
    ev_set[emsi_pkg::EV_VOLT1_DIP] = volt1_dip_flag_in;
    ev_set[emsi_pkg::EV_TEMP_UPDATED] = temperature_updated_flag_in;
    ev_set[emsi_pkg::EV_FREQ_UPDATED] = ratio_update;
    ev_set[emsi_pkg::EV_BAD_COMMAND] = bad_command_flag_in;
    ev_set[emsi_pkg::EV_RX_CHECKSUM] = receive_checksum_fault_in;
    ev_set[emsi_pkg::EV_ROM_CRC] = rom_crc_fault_in;
    ev_set[emsi_pkg::EV_RX_TIMEOUT] = receive_timeout_flag_in;
  end

  // Only ones in the written word clear
  assign ev_clr = wr_status ? req_in.wdata : 24'h000000;

  // Reserved bits are not built and read as zero
  genvar gi;
  generate
    for (gi = 0; gi < 24; gi++) begin : g_ev
      if (emsi_pkg::EV_IMPL_MASK[gi]) begin : g_impl
        emsi_event_bit #(
          .RST_VAL(emsi_pkg::RST_EVENT_STATUS[gi])
        ) u_bit (
          .clk_sys_in(clk_sys_in),
          .srst_in(srst_in),
          .set_in(ev_set[gi]),
          .clr_in(ev_clr[gi]),
          .flag_out(event_status[gi])
        );
      end else begin : g_rsvd
        assign event_status[gi] = 1'b0;
      end
    end
  endgenerate

  // ****************************************
  // Enable, lock and ratio registers
  // ****************************************
  logic [23:0] int_enable_r;
  logic [23:0] ratio_r;
  logic irq_n_r;

  // Interrupt enable, all disabled after reset
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      int_enable_r <= emsi_pkg::RST_INT_ENABLE;
    end else if (wr_enable) begin
      int_enable_r <= req_in.wdata & emsi_pkg::EV_IMPL_MASK;
    end
  end

  // Lock field: other codes are stored but only 0x16/0x09 change the state
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      lock_code_r <= 5'h00;
      lock_r <= 1'b0;
    end else if (wr_lock) begin
      lock_code_r <= req_in.wdata[4:0];
      if (req_in.wdata[4:0] == emsi_pkg::LOCK_CODE_SET) begin
        lock_r <= 1'b1;
      end else if (req_in.wdata[4:0] == emsi_pkg::LOCK_CODE_CLR) begin
        lock_r <= 1'b0;
      end
    end
  end

  // Ratio from the calculator or from the host
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ratio_r <= emsi_pkg::RST_RATIO;
    end else if (ratio_update) begin
      ratio_r <= ratio_calc_in;
    end else if (wr_ratio) begin
      ratio_r <= req_in.wdata;
    end
  end

  // Pin is low while any enabled flag is set; registered to avoid glitches
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      irq_n_r <= 1'b1;
    end else begin
      irq_n_r <= ~|(event_status & int_enable_r);
    end
  end

  // ****************************************
  // Read-only views
  // ****************************************
  logic [23:0] chip_cond;
  logic [23:0] sign_flags;

  assign chip_cond = (srst_in ? emsi_pkg::RST_CHIP_COND :
    ({8'h00, core_in.last_command_code, 4'h0, core_in.temp_modulator_osc, core_in.volt_modulator_osc,
      core_in.current2_modulator_osc, core_in.current1_modulator_osc}));
  assign sign_flags = {18'h0, core_in.reactive_total_negative, core_in.reactive2_negative,
    core_in.reactive1_negative, core_in.active_total_negative, core_in.active2_negative,
    core_in.active1_negative};

  // ****************************************
  // Read mux
  // ****************************************
  logic [23:0] rdata_nxt;
  logic [23:0] rdata_r;
  logic rvalid_r;

  assign rdata_nxt =
    hit(req_in.addr, emsi_pkg::ADDR_INT_ENABLE) ? int_enable_r :
    hit(req_in.addr, emsi_pkg::ADDR_EVENT_STATUS) ? event_status :
    hit(req_in.addr, emsi_pkg::ADDR_CHIP_COND) ? (chip_cond & emsi_pkg::CC_IMPL_MASK) :
    hit(req_in.addr, emsi_pkg::ADDR_SIGN_FLAGS) ? (sign_flags & emsi_pkg::SIGN_IMPL_MASK) :
    hit(req_in.addr, emsi_pkg::ADDR_LOCK) ? {19'h0, lock_code_r} :
    hit(req_in.addr, emsi_pkg::ADDR_RATIO) ? ratio_r : 24'h000000;

  // Read data one cycle after the request
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      rdata_r <= 24'h000000;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= req_in.rd ? rdata_nxt : rdata_r;
      rvalid_r <= req_in.rd;
    end
  end

  assign rdata_out = rdata_r;
  assign rvalid_out = rvalid_r;
  assign line_to_sample_ratio_out = ratio_r;
  assign host_write_lock_out = lock_r;
  assign irq_n_out = irq_n_r;

endmodule

// [emsi_status_irq_monitor.sv]
`timescale 1ns/1ps
// ****************************************
// Port checker for status and interrupt block
// ****************************************
module emsi_status_irq_monitor (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input emsi_pkg::emsi_req_s req_in,
  input wire logic [23:0] rdata_out,
  input wire logic rvalid_out,
  input wire logic wr_blocked_out,
  input wire logic host_write_lock_out,
  input wire logic irq_n_out,
  input wire logic bad_command_flag_in,
  input wire logic auto_frequency_enable_in,
  input wire logic ratio_calc_valid_in,
  input wire logic [23:0] ratio_calc_in,
  input wire logic [23:0] line_to_sample_ratio_out
);
  logic [23:0] en_r;
  wire en_wr = req_in.wr && req_in.addr == emsi_pkg::ADDR_INT_ENABLE && !wr_blocked_out;
  wire lck_wr = req_in.wr && req_in.addr == emsi_pkg::ADDR_LOCK;
  // Shadow of the enable register, so the pin can be judged from ports alone
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) en_r <= 24'h000000;
    else if (en_wr) en_r <= req_in.wdata & emsi_pkg::EV_IMPL_MASK;
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  rd_answer_a:
    assert property (req_in.rd |=> rvalid_out) else $error("read not answered");
  rdata_hold_a:
    assert property (!req_in.rd |=> $stable(rdata_out)) else $error("read data moved");
  lock_refuse_a:
    assert property (host_write_lock_out && req_in.wr && (req_in.addr == emsi_pkg::ADDR_INT_ENABLE ||
      req_in.addr == emsi_pkg::ADDR_RATIO) |-> wr_blocked_out) else $error("locked write taken");
  lock_pass_a:
    assert property (wr_blocked_out |-> host_write_lock_out && req_in.wr && !lck_wr &&
      req_in.addr != emsi_pkg::ADDR_EVENT_STATUS) else $error("write refused wrongly");
  lock_set_a:
    assert property (lck_wr && req_in.wdata[4:0] == emsi_pkg::LOCK_CODE_SET |=> host_write_lock_out)
      else $error("lock not set");
  lock_clr_a:
    assert property (lck_wr && req_in.wdata[4:0] == emsi_pkg::LOCK_CODE_CLR |=> !host_write_lock_out)
      else $error("lock not cleared");
  irq_raise_a:
    assert property (en_r[3] && bad_command_flag_in && !req_in.wr |-> ##2 !irq_n_out)
      else $error("pin not driven low");
  irq_masked_a:
    assert property (en_r == 24'h000000 |=> irq_n_out) else $error("masked pin active");
  ratio_hold_a:
    assert property (auto_frequency_enable_in && !ratio_calc_valid_in |=> $stable(line_to_sample_ratio_out))
      else $error("ratio changed in auto mode");
  ratio_load_a:
    assert property (auto_frequency_enable_in && ratio_calc_valid_in |=>
      line_to_sample_ratio_out == $past(ratio_calc_in)) else $error("ratio not loaded");
endmodule
bind emsi_status_irq emsi_status_irq_monitor mon (.clk_sys_in, .srst_in, .req_in, .rdata_out, .rvalid_out,
  .wr_blocked_out, .host_write_lock_out, .irq_n_out, .bad_command_flag_in, .auto_frequency_enable_in,
  .ratio_calc_valid_in, .ratio_calc_in, .line_to_sample_ratio_out);

// [emsi_host_model.sv]
`timescale 1ns/1ps
// ****************************************
// Host side: counts assertions of the pin
// ****************************************
module emsi_host_model (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic irq_n_in,
  output logic [7:0] irq_count_out
);
  logic irq_n_r;
  // Edge detect, since a held level must count once only
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      irq_n_r <= 1'b1;
      irq_count_out <= 8'h00;
    end else begin
      irq_n_r <= irq_n_in;
      if (irq_n_r && !irq_n_in) irq_count_out <= irq_count_out + 8'h01;
    end
  end
endmodule

// [energy_meter_status_interrupt_test.sv]
`timescale 1ns/1ps
// ****************************************
// Bench for status and interrupt block
// ****************************************
module energy_meter_status_interrupt_test;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  emsi_pkg::emsi_req_s req = '0;
  emsi_pkg::emsi_core_s core = {8'h18, 10'h000};
  logic [25:0] ev = 26'h0;
  logic afc = 1'b0;
  logic [23:0] calc = 24'h0;
  logic [23:0] rdata, ratio;
  logic rvalid, blocked, lock, irq_n, b;
  logic [7:0] irq_cnt;
  int bad_count = 0;
  int total_checks = 0;
  // Clock, 5 ns period
  always #2.5 clk_sys_in = ~clk_sys_in;
  emsi_status_irq uut (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .req_in(req), .rdata_out(rdata),
    .rvalid_out(rvalid), .wr_blocked_out(blocked), .low_rate_results_ready_in(ev[23]),
    .instruction_done_in(ev[24]), .reset_seq_done_in(ev[25]), .sample_results_ready_in(ev[22]),
    .watchdog_overflow_flag_in(ev[21]), .calc_overrun_flag_in(ev[18]), .volt2_swell_flag_in(ev[17]),
    .volt1_swell_flag_in(ev[16]), .power2_range_flag_in(ev[15]), .power1_range_flag_in(ev[14]),
    .current2_range_flag_in(ev[13]), .current1_range_flag_in(ev[12]), .volt2_range_flag_in(ev[11]),
    .volt1_range_flag_in(ev[10]), .current2_over_flag_in(ev[9]), .current1_over_flag_in(ev[8]),
    .volt2_dip_flag_in(ev[7]), .volt1_dip_flag_in(ev[6]), .temperature_updated_flag_in(ev[5]),
    .bad_command_flag_in(ev[3]), .receive_checksum_fault_in(ev[2]), .rom_crc_fault_in(ev[1]),
    .receive_timeout_flag_in(ev[0]), .core_in(core), .auto_frequency_enable_in(afc),
    .ratio_calc_valid_in(ev[4]), .ratio_calc_in(calc), .line_to_sample_ratio_out(ratio),
    .host_write_lock_out(lock), .irq_n_out(irq_n));
  emsi_host_model host (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .irq_n_in(irq_n), .irq_count_out(irq_cnt));
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Requests change at the falling edge and span one rising edge
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    @(negedge clk_sys_in);
    req = {1'b1, 1'b0, a, d};
    #1 b = blocked;
    @(negedge clk_sys_in);
    req = '0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [23:0] e, input string n);
    int i;
    @(negedge clk_sys_in);
    req = {1'b0, 1'b1, a, 24'h0};
    @(negedge clk_sys_in);
    req = '0;
    for (i = 0; i < 4 && rvalid !== 1'b1; i++) @(negedge clk_sys_in);
    if (rvalid !== 1'b1) begin
      bad_count++;
      wrap_up();
    end
    chk(n, e, rdata);
  endtask
  task automatic pulse(input int k);
    @(negedge clk_sys_in);
    ev[k] = 1'b1;
    @(negedge clk_sys_in);
    ev[k] = 1'b0;
  endtask
  task automatic t_reset();
    rd(emsi_pkg::ADDR_INT_ENABLE, 24'h000000, "enable");
    rd(emsi_pkg::ADDR_EVENT_STATUS, 24'h800000, "status");
    rd(emsi_pkg::ADDR_SIGN_FLAGS, 24'h000000, "sign");
    rd(emsi_pkg::ADDR_RATIO, 24'h01999A, "ratio");
    rd(6'h3F, 24'h000000, "unmapped");
    wr(emsi_pkg::ADDR_EVENT_STATUS, 24'h7FFFFF);
    rd(emsi_pkg::ADDR_EVENT_STATUS, 24'h800000, "zero write");
    wr(emsi_pkg::ADDR_EVENT_STATUS, 24'h800000);
    rd(emsi_pkg::ADDR_EVENT_STATUS, 24'h000000, "one write");
  endtask
  // Every event source, bit 23 from all three, reserved and ratio bits skipped
  task automatic t_events();
    for (int k = 0; k < 26; k++) begin
      if (k == 19 || k == 20 || k == 4) continue;
      pulse(k);
      rd(emsi_pkg::ADDR_EVENT_STATUS, (k > 23) ? 24'h800000 : 24'h1 << k, "event");
      wr(emsi_pkg::ADDR_EVENT_STATUS, 24'hFFFFFF);
    end
  endtask
  task automatic t_irq();
    wr(emsi_pkg::ADDR_INT_ENABLE, 24'hFFFFFF);
    rd(emsi_pkg::ADDR_INT_ENABLE, 24'hE7FFFF, "enable rw");
    pulse(3);
    @(negedge clk_sys_in);
    chk("pin low", 24'h0, {23'h0, irq_n});
    // Host edge detector counts one edge after the pin falls
    @(negedge clk_sys_in);
    chk("host count", 24'h1, {16'h0, irq_cnt});
    wr(emsi_pkg::ADDR_EVENT_STATUS, 24'h000008);
    @(negedge clk_sys_in);
    chk("pin released", 24'h1, {23'h0, irq_n});
    wr(emsi_pkg::ADDR_INT_ENABLE, 24'hFFFFF7);
    pulse(3);
    @(negedge clk_sys_in);
    chk("pin masked", 24'h1, {23'h0, irq_n});
    rd(emsi_pkg::ADDR_EVENT_STATUS, 24'h000008, "masked set");
    wr(emsi_pkg::ADDR_EVENT_STATUS, 24'h000008);
  endtask
  task automatic t_lock();
    wr(emsi_pkg::ADDR_LOCK, {19'h0, emsi_pkg::LOCK_CODE_SET});
    chk("locked", 24'h1, {23'h0, lock});
    wr(emsi_pkg::ADDR_INT_ENABLE, 24'h000010);
    chk("refused", 24'h1, {23'h0, b});
    rd(emsi_pkg::ADDR_INT_ENABLE, 24'hE7FFF7, "enable locked");
    wr(emsi_pkg::ADDR_RATIO, 24'h111111);
    rd(emsi_pkg::ADDR_RATIO, 24'h01999A, "ratio locked");
    pulse(0);
    wr(emsi_pkg::ADDR_EVENT_STATUS, 24'h000001);
    rd(emsi_pkg::ADDR_EVENT_STATUS, 24'h000000, "status locked");
    wr(emsi_pkg::ADDR_LOCK, {19'h0, emsi_pkg::LOCK_CODE_CLR});
    wr(emsi_pkg::ADDR_INT_ENABLE, 24'h000010);
    rd(emsi_pkg::ADDR_INT_ENABLE, 24'h000010, "enable unlocked");
  endtask
  // Host writes the ratio only while the calculator is off
  task automatic t_ratio();
    wr(emsi_pkg::ADDR_RATIO, 24'h123456);
    rd(emsi_pkg::ADDR_RATIO, 24'h123456, "ratio host");
    afc = 1'b1;
    wr(emsi_pkg::ADDR_RATIO, 24'h654321);
    rd(emsi_pkg::ADDR_RATIO, 24'h123456, "ratio auto");
    calc = 24'h0147AE;
    pulse(4);
    chk("ratio out", 24'h0147AE, ratio);
    rd(emsi_pkg::ADDR_EVENT_STATUS, 24'h000010, "ratio update");
    // Third falling edge: bad command, bit 0 while locked, then ratio update
    chk("host count", 24'h3, {16'h0, irq_cnt});
  endtask
  task automatic t_core();
    core = {8'hA5, 4'b1010, 6'b101010};
    rd(emsi_pkg::ADDR_CHIP_COND, 24'h00A50A, "chip a");
    rd(emsi_pkg::ADDR_SIGN_FLAGS, 24'h00002A, "sign a");
    core = {8'h5A, 4'b0101, 6'b010101};
    rd(emsi_pkg::ADDR_CHIP_COND, 24'h005A05, "chip b");
    rd(emsi_pkg::ADDR_SIGN_FLAGS, 24'h000015, "sign b");
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    srst_in = 1'b0;
    t_reset();
    t_events();
    t_irq();
    t_lock();
    t_ratio();
    t_core();
    wrap_up();
  end
endmodule
